/* core/tdr_defines.vh */
// constants shared by the dual-port ram core and its port helpers
`ifndef TDR_DEFINES_VH
`define TDR_DEFINES_VH

// storage geometry
`define TDR_ADDR_W 12
`define TDR_DATA_W 16
`define TDR_WORDS 256
`define TDR_IDX_W 8
`define TDR_OFF_W 4
`define TDR_IDX_RANGE 11:4
`define TDR_OFF_RANGE 3:0

// width codes: port width is 1 << code
`define TDR_WCODE_W 3
`define TDR_WCODE_1 3'h0
`define TDR_WCODE_2 3'h1
`define TDR_WCODE_4 3'h2
`define TDR_WCODE_8 3'h3
`define TDR_WCODE_16 3'h4
`define TDR_LANE_1 16'h0001
`define TDR_LANE_2 16'h0003
`define TDR_LANE_4 16'h000f
`define TDR_LANE_8 16'h00ff
`define TDR_LANE_16 16'hffff

// inversion bits inside one port nibble
`define TDR_INV_CLK 0
`define TDR_INV_EN 1
`define TDR_INV_WE 2
`define TDR_INV_RST 3

// register byte offsets
`define TDR_REG_CFG 4'h0
`define TDR_REG_INV 4'h4
`define TDR_REG_STAT 4'h8

// register fields and reset values
`define TDR_CFG_A 2:0
`define TDR_CFG_B 6:4
`define TDR_CFG_RST 8'h44
`define TDR_INV_A 3:0
`define TDR_INV_B 7:4
`define TDR_INV_RSTV 8'h00
`define TDR_STAT_OPA 1:0
`define TDR_STAT_OPB 3:2
`define TDR_STAT_WW 4
`define TDR_STAT_WR 5

// last operation codes
`define TDR_OP_NONE 2'h0
`define TDR_OP_READ 2'h1
`define TDR_OP_WRITE 2'h2
`define TDR_OP_RESET 2'h3

`endif

/* core/tdr_port_in.v */
// input stage of one ram port: sampling, edge detection, cell decode
`timescale 1ns/100ps
`include "tdr_defines.vh"

module tdr_port_in (
  // system
  input wire clk_i,
  input wire rst_b_i,
  // configuration
  input wire [`TDR_WCODE_W-1:0] wcode_i,
  input wire [3:0] inv_i,
  // user port
  input wire port_clk_i,
  input wire en_i,
  input wire we_i,
  input wire rst_i,
  input wire [`TDR_ADDR_W-1:0] addr_i,
  input wire [`TDR_DATA_W-1:0] write_data_bus_i,
  // decoded access
  output wire access_o,
  output wire wr_o,
  output wire orst_o,
  output wire [`TDR_IDX_W-1:0] idx_o,
  output wire [`TDR_OFF_W-1:0] off_o,
  output wire [`TDR_DATA_W-1:0] lmask_o,
  output wire [`TDR_DATA_W-1:0] wmask_o,
  output wire [`TDR_DATA_W-1:0] wdata_o,
  output wire [`TDR_DATA_W-1:0] din_o
);

  reg clk_q;
  reg clk_prev;
  reg prime0;
  reg prime1;
  reg en_q;
  reg we_q;
  reg rst_q;
  reg [`TDR_ADDR_W-1:0] addr_q;
  reg [`TDR_DATA_W-1:0] din_q;
  wire [`TDR_ADDR_W-1:0] base;
  wire [`TDR_WCODE_W-1:0] sh;

  function [`TDR_DATA_W-1:0] lane_mask;
    input [`TDR_WCODE_W-1:0] code;
    begin
      case (code)
        `TDR_WCODE_1: lane_mask = `TDR_LANE_1;
        `TDR_WCODE_2: lane_mask = `TDR_LANE_2;
        `TDR_WCODE_4: lane_mask = `TDR_LANE_4;
        `TDR_WCODE_8: lane_mask = `TDR_LANE_8;
        default: lane_mask = `TDR_LANE_16;
      endcase
    end
  endfunction

  // every port input lands in a flop first; clk, en, we and rst after their inversion
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      clk_q <= 1'b0;
      clk_prev <= 1'b0;
      prime0 <= 1'b0;
      prime1 <= 1'b0;
      en_q <= 1'b0;
      we_q <= 1'b0;
      rst_q <= 1'b0;
      addr_q <= {`TDR_ADDR_W{1'b0}};
      din_q <= {`TDR_DATA_W{1'b0}};
    end
    else
    begin
      clk_q <= port_clk_i ^ inv_i[`TDR_INV_CLK]; // RULE15 RULE17
      clk_prev <= clk_q;
      prime0 <= 1'b1;
      prime1 <= prime0;
      en_q <= en_i ^ inv_i[`TDR_INV_EN]; // RULE1 RULE15
      we_q <= we_i ^ inv_i[`TDR_INV_WE]; // RULE1 RULE15
      rst_q <= rst_i ^ inv_i[`TDR_INV_RST]; // RULE1 RULE15
      addr_q <= addr_i; // RULE1
      din_q <= write_data_bus_i; // RULE1
    end
  end

  // priming hides the false edge an inverted idle clock shows at reset
  assign access_o = clk_q & ~clk_prev & prime1 & en_q; // RULE4 RULE8 RULE17
  assign wr_o = access_o & we_q; // RULE10
  assign orst_o = access_o & rst_q; // RULE8 RULE12

  // word a of width w holds cells (a+1)*w-1 .. a*w
  assign sh = (wcode_i > `TDR_WCODE_16) ? `TDR_WCODE_16 : wcode_i;
  assign base = addr_q << sh; // RULE7 RULE13 RULE16
  assign idx_o = base[`TDR_IDX_RANGE];
  assign off_o = base[`TDR_OFF_RANGE];
  assign lmask_o = lane_mask(sh);
  assign wmask_o = lane_mask(sh) << off_o;
  assign din_o = din_q & lane_mask(sh); // RULE13
  assign wdata_o = (din_q & lane_mask(sh)) << off_o;

endmodule // tdr_port_in

/* core/tdr_port_out.v */
// output latch of one ram port
`timescale 1ns/100ps
`include "tdr_defines.vh"

module tdr_port_out (
  // system
  input wire clk_i,
  input wire rst_b_i,
  // access of this port
  input wire access_i,
  input wire wr_i,
  input wire orst_i,
  input wire [`TDR_OFF_W-1:0] off_i,
  input wire [`TDR_DATA_W-1:0] lmask_i,
  input wire [`TDR_DATA_W-1:0] din_i,
  input wire [`TDR_DATA_W-1:0] rd_word_i,
  // data out
  output reg [`TDR_DATA_W-1:0] dout_o
);

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      dout_o <= {`TDR_DATA_W{1'b0}};
    else if (access_i) // RULE2 RULE5 RULE9
    begin
      if (orst_i)
        dout_o <= {`TDR_DATA_W{1'b0}}; // RULE12 RULE19
      else if (wr_i)
        dout_o <= din_i; // RULE10 RULE14
      else
        dout_o <= (rd_word_i >> off_i) & lmask_i; // RULE11 RULE14
    end
  end

endmodule // tdr_port_out

/* core/tdr_ram.v */
// true dual-port 4096-cell ram with avalon configuration registers
//
// Behaviour
// RULE1: each port registers all its inputs
// RULE2: no combinational address to output path
// RULE3: ports fully independent, no arbitration
// RULE4: one access per active port edge
// RULE5: output holds until next enabled access
// RULE6: both ports share 4096 single-bit cells
// RULE7: widths 1,2,4,8,16 set depth, address
// RULE8: enable gates read, write and output reset
// RULE9: disabled port keeps output, writes nothing
// RULE10: write stores data and mirrors it out
// RULE11: read presents addressed cells on output
// RULE12: output reset clears latch, memory untouched
// RULE13: address and data widths follow width
// RULE14: output shows last sampled address or write
// RULE15: clk, en, we, rst each invertible
// RULE16: word a covers cells (a+1)w-1..aw
// RULE17: inputs sampled on rising port clock
// RULE18: same-cell collisions give invalid data
// RULE19: reset with write still writes memory
`timescale 1ns/100ps
`include "tdr_defines.vh"

module tdr_ram (
  // system
  input wire MCLK_I,
  input wire RST_B_I,
  // avalon-mm slave
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output wire AVS_WAITREQUEST_O,
  // port a
  input wire PA_CLK_I,
  input wire PA_EN_I,
  input wire PA_WE_I,
  input wire PA_RST_I,
  input wire [`TDR_ADDR_W-1:0] PA_ADDR_I,
  input wire [`TDR_DATA_W-1:0] PA_WRITE_DATA_BUS_I,
  output wire [`TDR_DATA_W-1:0] PA_DATA_O,
  // port b
  input wire PB_CLK_I,
  input wire PB_EN_I,
  input wire PB_WE_I,
  input wire PB_RST_I,
  input wire [`TDR_ADDR_W-1:0] PB_ADDR_I,
  input wire [`TDR_DATA_W-1:0] PB_WRITE_DATA_BUS_I,
  output wire [`TDR_DATA_W-1:0] PB_DATA_O
);

  // shared storage, 256 words of 16 cells
  reg [`TDR_DATA_W-1:0] mem [0:`TDR_WORDS-1];

  // configuration and status
  reg [7:0] cfg;
  reg [7:0] inv;
  reg [1:0] op_a;
  reg [1:0] op_b;
  reg coll_ww;
  reg coll_wr;
  reg ack;

  // decoded port a
  wire acc_a;
  wire wr_a;
  wire orst_a;
  wire [`TDR_IDX_W-1:0] idx_a;
  wire [`TDR_OFF_W-1:0] off_a;
  wire [`TDR_DATA_W-1:0] lmask_a;
  wire [`TDR_DATA_W-1:0] wmask_a;
  wire [`TDR_DATA_W-1:0] wdata_a;
  wire [`TDR_DATA_W-1:0] din_a;
  wire [`TDR_DATA_W-1:0] rd_a;

  // decoded port b
  wire acc_b;
  wire wr_b;
  wire orst_b;
  wire [`TDR_IDX_W-1:0] idx_b;
  wire [`TDR_OFF_W-1:0] off_b;
  wire [`TDR_DATA_W-1:0] lmask_b;
  wire [`TDR_DATA_W-1:0] wmask_b;
  wire [`TDR_DATA_W-1:0] wdata_b;
  wire [`TDR_DATA_W-1:0] din_b;
  wire [`TDR_DATA_W-1:0] rd_b;

  wire same_word;
  wire overlap;
  wire hit_ww;
  wire hit_wr;
  wire bus_req;
  wire bus_take;
  reg [31:0] next_readdata;

  function [1:0] op_code;
    input acc;
    input wr;
    input orst;
    begin
      if (!acc)
        op_code = `TDR_OP_NONE;
      else if (orst)
        op_code = `TDR_OP_RESET;
      else if (wr)
        op_code = `TDR_OP_WRITE;
      else
        op_code = `TDR_OP_READ;
    end
  endfunction

  // each port decodes alone; nothing here arbitrates between them
  tdr_port_in u_in_a (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .wcode_i(cfg[`TDR_CFG_A]),
    .inv_i(inv[`TDR_INV_A]),
    .port_clk_i(PA_CLK_I),
    .en_i(PA_EN_I),
    .we_i(PA_WE_I),
    .rst_i(PA_RST_I),
    .addr_i(PA_ADDR_I),
    .write_data_bus_i(PA_WRITE_DATA_BUS_I),
    .access_o(acc_a),
    .wr_o(wr_a),
    .orst_o(orst_a),
    .idx_o(idx_a),
    .off_o(off_a),
    .lmask_o(lmask_a),
    .wmask_o(wmask_a),
    .wdata_o(wdata_a),
    .din_o(din_a)
  ); // RULE3

  tdr_port_in u_in_b (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .wcode_i(cfg[`TDR_CFG_B]),
    .inv_i(inv[`TDR_INV_B]),
    .port_clk_i(PB_CLK_I),
    .en_i(PB_EN_I),
    .we_i(PB_WE_I),
    .rst_i(PB_RST_I),
    .addr_i(PB_ADDR_I),
    .write_data_bus_i(PB_WRITE_DATA_BUS_I),
    .access_o(acc_b),
    .wr_o(wr_b),
    .orst_o(orst_b),
    .idx_o(idx_b),
    .off_o(off_b),
    .lmask_o(lmask_b),
    .wmask_o(wmask_b),
    .wdata_o(wdata_b),
    .din_o(din_b)
  ); // RULE3

  // reads see the array before this edge's writes
  assign rd_a = mem[idx_a]; // RULE6 RULE11
  assign rd_b = mem[idx_b]; // RULE6 RULE11

  // both ports touch the same array; disjoint cells of one word merge
  always @(posedge MCLK_I)
  begin
    if (wr_a && wr_b && same_word)
      mem[idx_a] <= (mem[idx_a] & ~wmask_a & ~wmask_b) |
                    (wdata_a & ~wmask_b) | wdata_b; // RULE6 RULE18
    else
    begin
      if (wr_a)
        mem[idx_a] <= (mem[idx_a] & ~wmask_a) | wdata_a; // RULE10 RULE19
      if (wr_b)
        mem[idx_b] <= (mem[idx_b] & ~wmask_b) | wdata_b; // RULE10 RULE19
    end
  end

  tdr_port_out u_out_a (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .access_i(acc_a),
    .wr_i(wr_a),
    .orst_i(orst_a),
    .off_i(off_a),
    .lmask_i(lmask_a),
    .din_i(din_a),
    .rd_word_i(rd_a),
    .dout_o(PA_DATA_O)
  );

  tdr_port_out u_out_b (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .access_i(acc_b),
    .wr_i(wr_b),
    .orst_i(orst_b),
    .off_i(off_b),
    .lmask_i(lmask_b),
    .din_i(din_b),
    .rd_word_i(rd_b),
    .dout_o(PB_DATA_O)
  );

  // collision watch: the stored or read value is not trusted then
  assign same_word = (idx_a == idx_b);
  assign overlap = same_word && ((wmask_a & wmask_b) != {`TDR_DATA_W{1'b0}});
  assign hit_ww = wr_a && wr_b && overlap; // RULE18
  assign hit_wr = overlap && ((wr_a && acc_b && !wr_b) ||
                              (wr_b && acc_a && !wr_a)); // RULE18

  // avalon: one wait state; read data latched at the edge that sets ack, write taken at the edge after it
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = bus_req & ~ack;
  assign bus_take = bus_req & ack;

  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ack <= 1'b0;
    else
      ack <= bus_req & ~ack;
  end

  // unmapped offsets read as zero so software can probe safely
  always @*
  begin
    case (AVS_ADDRESS_I)
      `TDR_REG_CFG: next_readdata = {24'h000000, cfg};
      `TDR_REG_INV: next_readdata = {24'h000000, inv};
      `TDR_REG_STAT:
        next_readdata = {26'h0000000, coll_wr, coll_ww, op_b, op_a};
      default: next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      AVS_READDATA_O <= 32'h00000000;
    else if (AVS_READ_I && !ack)
      AVS_READDATA_O <= next_readdata;
  end

  // configuration: width codes and control inversions
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      cfg <= `TDR_CFG_RST;
      inv <= `TDR_INV_RSTV;
    end
    else if (bus_take && AVS_WRITE_I && AVS_BYTEENABLE_I[0])
    begin
      case (AVS_ADDRESS_I)
        `TDR_REG_CFG: cfg <= AVS_WRITEDATA_I[7:0]; // RULE7
        `TDR_REG_INV: inv <= AVS_WRITEDATA_I[7:0]; // RULE15
        default:
        begin
          cfg <= cfg;
          inv <= inv;
        end
      endcase
    end
  end

  // status: last operation per port, sticky collision flags
  // a collision in the clearing cycle survives the clear
  always @(posedge MCLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      op_a <= `TDR_OP_NONE;
      op_b <= `TDR_OP_NONE;
      coll_ww <= 1'b0;
      coll_wr <= 1'b0;
    end
    else
    begin
      if (acc_a)
        op_a <= op_code(acc_a, wr_a, orst_a);
      if (acc_b)
        op_b <= op_code(acc_b, wr_b, orst_b);
      if (hit_ww)
        coll_ww <= 1'b1;
      else if (bus_take && AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
               AVS_ADDRESS_I == `TDR_REG_STAT &&
               AVS_WRITEDATA_I[`TDR_STAT_WW])
        coll_ww <= 1'b0;
      if (hit_wr)
        coll_wr <= 1'b1;
      else if (bus_take && AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
               AVS_ADDRESS_I == `TDR_REG_STAT &&
               AVS_WRITEDATA_I[`TDR_STAT_WR])
        coll_wr <= 1'b0;
    end
  end

endmodule // tdr_ram

/* testbench/tdr_ram_checker.sv */
// assertion checker for the dual-port ram top
`timescale 1ns/100ps
`include "tdr_defines.vh"
module tdr_ram_checker (
  // system
  input wire MCLK_I,
  input wire RST_B_I,
  // avalon
  input wire [3:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  // ports
  input wire PA_CLK_I,
  input wire PA_EN_I,
  input wire PA_RST_I,
  input wire [`TDR_DATA_W-1:0] PA_DATA_O,
  input wire PB_CLK_I,
  input wire PB_EN_I,
  input wire PB_WE_I,
  input wire PB_RST_I,
  input wire [`TDR_DATA_W-1:0] PB_WRITE_DATA_BUS_I,
  input wire [`TDR_DATA_W-1:0] PB_DATA_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_a_rise;
    PA_CLK_I && !$past(PA_CLK_I);
  endsequence
  sequence s_b_rise;
    PB_CLK_I && !$past(PB_CLK_I);
  endsequence
  a_pa_out_hold:
    assert property (!$stable(PA_DATA_O) |->
      $past(PA_CLK_I, 2) && !$past(PA_CLK_I, 3)) else $error("a moved");
  a_pb_out_hold:
    assert property (!$stable(PB_DATA_O) |->
      $past(PB_CLK_I, 2) && !$past(PB_CLK_I, 3)) else $error("b moved");
  a_pb_wr_mirror:
    assert property (s_b_rise ##0 (PB_EN_I && PB_WE_I && !PB_RST_I) |=>
      ##1 PB_DATA_O == $past(PB_WRITE_DATA_BUS_I, 2))
      else $error("b no mirror");
  a_pb_rst_zero:
    assert property (s_b_rise ##0 (PB_EN_I && PB_RST_I) |=>
      ##1 PB_DATA_O == 16'h0) else $error("b not cleared");
  a_pa_rst_zero:
    assert property (s_a_rise ##0 (PA_EN_I && PA_RST_I) |=>
      ##1 PA_DATA_O == 16'h0) else $error("a not cleared");
  a_pb_off_hold:
    assert property (s_b_rise ##0 !PB_EN_I |=> ##1 $stable(PB_DATA_O))
      else $error("b changed while off");
  a_bus_one_wait:
    assert property ($rose(AVS_READ_I || AVS_WRITE_I) |->
      AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("bad wait");
  a_bus_unmapped_zero:
    assert property (AVS_READ_I && !AVS_WAITREQUEST_O &&
      AVS_ADDRESS_I == 4'hc |-> AVS_READDATA_O == 32'h0)
      else $error("unmapped nonzero");
endmodule // tdr_ram_checker

bind tdr_ram tdr_ram_checker u_chk (.MCLK_I, .RST_B_I, .AVS_ADDRESS_I,
  .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
  .PA_CLK_I, .PA_EN_I, .PA_RST_I, .PA_DATA_O, .PB_CLK_I, .PB_EN_I,
  .PB_WE_I, .PB_RST_I, .PB_WRITE_DATA_BUS_I, .PB_DATA_O);

/* testbench/tdr_user.sv */
// user logic model driving one ram port
`timescale 1ns/100ps
`include "tdr_defines.vh"
module tdr_user (
  // system
  input wire mclk_i,
  // port pins
  output logic clk_o,
  output logic en_o,
  output logic we_o,
  output logic rst_o,
  output logic [`TDR_ADDR_W-1:0] addr_o,
  output logic [`TDR_DATA_W-1:0] write_data_bus_o,
  input wire [`TDR_DATA_W-1:0] dout_i
);
  initial
  begin
    clk_o = 1'b0;
    {en_o, we_o, rst_o} = 3'h0;
    addr_o = 12'h0;
    write_data_bus_o = 16'h0;
  end
  // ctl is en, we, rst; one access at a time, never colliding
  task automatic acc(input bit [2:0] ctl, input logic [11:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk_i);
    clk_o <= 1'b1;
    {en_o, we_o, rst_o} <= ctl;
    addr_o <= a;
    write_data_bus_o <= d;
    @(posedge mclk_i);
    // scrambled once sampled: an unregistered input would show
    clk_o <= 1'b0;
    {en_o, we_o, rst_o} <= ~ctl;
    addr_o <= ~a;
    write_data_bus_o <= ~d;
    repeat (2) @(posedge mclk_i);
    q = dout_i;
  endtask
endmodule // tdr_user

/* testbench/tdr_ram_tb_top.sv */
// self-checking bench for the dual-port ram
`timescale 1ns/100ps
`include "tdr_defines.vh"
module tdr_ram_tb_top;
  logic mclk;
  logic rst_b;
  logic [3:0] av_addr;
  logic av_rd;
  logic av_wr;
  logic [31:0] av_wd;
  wire [31:0] av_rdata;
  wire av_wait;
  wire pa_clk, pa_en, pa_we, pa_rst, pb_clk, pb_en, pb_we, pb_rst;
  wire [`TDR_ADDR_W-1:0] pa_addr, pb_addr;
  wire [`TDR_DATA_W-1:0] pa_wdata, pb_wdata, pa_do, pb_do;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] r;
  logic [15:0] q;

  tdr_ram u_dut (.MCLK_I(mclk), .RST_B_I(rst_b), .AVS_ADDRESS_I(av_addr),
    .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wd),
    .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(av_rdata),
    .AVS_WAITREQUEST_O(av_wait), .PA_CLK_I(pa_clk), .PA_EN_I(pa_en),
    .PA_WE_I(pa_we), .PA_RST_I(pa_rst), .PA_ADDR_I(pa_addr),
    .PA_WRITE_DATA_BUS_I(pa_wdata), .PA_DATA_O(pa_do), .PB_CLK_I(pb_clk),
    .PB_EN_I(pb_en), .PB_WE_I(pb_we), .PB_RST_I(pb_rst),
    .PB_ADDR_I(pb_addr), .PB_WRITE_DATA_BUS_I(pb_wdata), .PB_DATA_O(pb_do));
  tdr_user u_pa (.mclk_i(mclk), .clk_o(pa_clk), .en_o(pa_en), .we_o(pa_we),
    .rst_o(pa_rst), .addr_o(pa_addr), .write_data_bus_o(pa_wdata),
    .dout_i(pa_do));
  tdr_user u_pb (.mclk_i(mclk), .clk_o(pb_clk), .en_o(pb_en), .we_o(pb_we),
    .rst_o(pb_rst), .addr_o(pb_addr), .write_data_bus_o(pb_wdata),
    .dout_i(pb_do));

  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // waitrequest low and read data are taken at one and the same edge
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    av_addr <= a;
    av_wd <= {24'h0, d};
    av_wr <= w;
    av_rd <= !w;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (av_wait !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      chk("waitrequest", 16'h0, 16'h1);
      stop_test();
    end
    r = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic t_regs;
    bus(0, `TDR_REG_CFG, 8'h0);
    chk("cfg", 16'h0044, r[15:0]);
    bus(0, `TDR_REG_INV, 8'h0);
    chk("inv", 16'h0000, r[15:0]);
    bus(1, 4'hc, 8'hff);
    bus(0, 4'hc, 8'h0);
    chk("unmapped", 16'h0, r[15:0]);
  endtask

  task automatic t_basic;
    u_pa.acc(3'b110, 12'h07e, 16'h9999, q);
    chk("pa_wr", 16'h9999, q);
    u_pb.acc(3'b100, 12'h07e, 16'h0, q);
    chk("pb_rd", 16'h9999, q);
    u_pa.acc(3'b010, 12'h07e, 16'h1234, q);
    chk("pa_off", 16'h9999, q);
    u_pb.acc(3'b101, 12'hf7e, 16'h0, q);
    chk("pb_rst", 16'h0, q);
    u_pa.acc(3'b100, 12'hf7e, 16'h0, q);
    chk("pa_rd", 16'h9999, q);
    u_pb.acc(3'b111, 12'h00f, 16'haaaa, q);
    chk("pb_rst_wr", 16'h0, q);
    u_pb.acc(3'b010, 12'h00f, 16'h5555, q);
    chk("pb_off", 16'h0, q);
    u_pa.acc(3'b100, 12'h00f, 16'h0, q);
    chk("pa_rd_wr", 16'haaaa, q);
    u_pa.acc(3'b101, 12'h00f, 16'h0, q);
    chk("pa_rst", 16'h0, q);
    bus(0, `TDR_REG_STAT, 8'h0);
    chk("stat", 16'h000f, r[15:0]);
  endtask

  // port a word overlapping cells 80..95 that port b holds as word 5
  task automatic t_width;
    int c, s, m;
    for (c = 0; c < 5; c++)
    begin
      m = (1 << (1 << c)) - 1;
      s = ((88 >> c) << c) - 80;
      bus(1, `TDR_REG_CFG, 8'h40 | 8'(c));
      u_pb.acc(3'b110, 12'h005, 16'ha5c3, q);
      u_pa.acc(3'b100, 12'(88 >> c), 16'h0, q);
      chk("pa_rd", 16'((32'ha5c3 >> s) & m), q);
      u_pa.acc(3'b110, 12'(88 >> c), 16'hffff, q);
      chk("pa_wr", 16'(m), q);
      u_pb.acc(3'b100, 12'h005, 16'h0, q);
      chk("pb_rd", 16'(32'ha5c3 | (m << s)), q);
    end
  endtask

  task automatic t_inv;
    bus(1, `TDR_REG_INV, 8'h06);
    u_pa.acc(3'b000, 12'h033, 16'h5a5a, q);
    chk("pa_inv", 16'h5a5a, q);
    u_pa.acc(3'b110, 12'h033, 16'h1111, q);
    chk("pa_inv_off", 16'h5a5a, q);
    bus(1, `TDR_REG_INV, 8'h00);
    u_pb.acc(3'b100, 12'h033, 16'h0, q);
    chk("pb_inv", 16'h5a5a, q);
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    rst_b = 1'b0;
    av_addr = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_basic();
    t_width();
    t_inv();
    stop_test();
  end
endmodule // tdr_ram_tb_top
